// *** design/svwd_regs.svh ***
// Purpose: timing and width constants of the supervisor watchdog
// Assumes: block clock at 25 MHz
// Notes:   periods are least times, so the cycle counts round up
`ifndef SVWD_REGS_SVH
`define SVWD_REGS_SVH

// block clock period in nanoseconds
`define SVWD_CLK_PERIOD_NS 40
// watchdog timeout period in nanoseconds
`define SVWD_WD_TIME_NS 200000
// reset-hold period in nanoseconds
`define SVWD_RST_TIME_NS 20000
// derived cycle counts, rounded up, never below one
`define SVWD_WD_CYC ((`SVWD_WD_TIME_NS + `SVWD_CLK_PERIOD_NS - 1) / `SVWD_CLK_PERIOD_NS)
`define SVWD_RST_CYC ((`SVWD_RST_TIME_NS + `SVWD_CLK_PERIOD_NS - 1) / `SVWD_CLK_PERIOD_NS)
// width of the shared period counter
`define SVWD_CNT_W 16
// counter cleared value and step
`define SVWD_CNT_ZERO 16'h0000
`define SVWD_CNT_ONE 16'h0001
// output levels after reset
`define SVWD_RST_N_INIT 1'b0
`define SVWD_FAULT_N_INIT 1'b1

`endif

// *** design/svwd_pkg.sv ***
// Purpose: types shared by the supervisor watchdog files
// Assumes: nothing
// Notes:   state codes are left to the tools
package svwd_pkg;

  // phases of the reset and watchdog sequence
  typedef enum logic [1:0] {
    SVWD_ST_UNDERVOLT,
    SVWD_ST_HOLD,
    SVWD_ST_RUN
  } svwd_state_t;

endpackage : svwd_pkg

// *** design/svwd_kick_det.sv ***
// Purpose: edge detection on the watchdog kick input
// Assumes: kick level and high-impedance flag are synchronous to the clock
// Notes:   no edge is reported across a high-impedance stretch
`timescale 1ns/1ps
`include "svwd_regs.svh"

module svwd_kick_det (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // kick pin view
  input wire logic watchdog_kick_in_i,
  input wire logic kick_hiz_i,
  // detected events
  output logic kick_edge_o,
  output logic kick_hiz_o
);

  logic sample_reg;
  logic prev_reg;
  logic valid_reg;
  logic prev_valid_reg;

  // two successive samples of the kick level and their validity
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sample_reg <= 1'b0;
      prev_reg <= 1'b0;
      valid_reg <= 1'b0;
      prev_valid_reg <= 1'b0;
    end else begin
      sample_reg <= watchdog_kick_in_i;
      prev_reg <= sample_reg;
      valid_reg <= !kick_hiz_i;
      prev_valid_reg <= valid_reg;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      kick_edge_o <= 1'b0;
      kick_hiz_o <= 1'b1;
    end else begin
      kick_edge_o <= valid_reg && prev_valid_reg && (sample_reg != prev_reg);
      kick_hiz_o <= !valid_reg;
    end
  end

endmodule : svwd_kick_det

// *** design/svwd_top.sv ***
// Purpose: watchdog and reset-output logic of a multi-supply supervisor
// Assumes: undervoltage flag and kick pin are synchronous to clk_sys_i
// Notes:   one counter serves both the watchdog and the reset-hold period
`timescale 1ns/1ps
`include "svwd_regs.svh"

module svwd_top #(
  parameter int unsigned WD_CYC = `SVWD_WD_CYC,
  parameter int unsigned RST_CYC = `SVWD_RST_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // supply monitor
  input wire logic undervolt_i,
  // watchdog kick pin
  input wire logic watchdog_kick_in_i,
  input wire logic kick_hiz_i,
  // supervisor outputs
  output logic sys_rst_n_o,
  output logic watchdog_fault_out_n_o
);

  // last counts of each period, at counter width
  // periods in block cycles
  localparam logic [`SVWD_CNT_W-1:0] WD_LAST = (`SVWD_CNT_W)'(WD_CYC - 1);
  localparam logic [`SVWD_CNT_W-1:0] RST_LAST = (`SVWD_CNT_W)'(RST_CYC - 1);

  svwd_pkg::svwd_state_t state_reg;
  svwd_pkg::svwd_state_t state_next;
  logic [`SVWD_CNT_W-1:0] cnt_reg;
  logic [`SVWD_CNT_W-1:0] cnt_next;
  logic rst_n_reg;
  logic rst_n_next;
  logic fault_n_reg;
  logic fault_n_next;
  logic kick_edge;
  logic kick_hiz;
  logic wd_expire;
  logic hold_done;

  // kick edge and float detection
  svwd_kick_det u_kick_det (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .watchdog_kick_in_i(watchdog_kick_in_i),
    .kick_hiz_i(kick_hiz_i),
    .kick_edge_o(kick_edge),
    .kick_hiz_o(kick_hiz)
  );

  // period end conditions
  assign wd_expire = (state_reg == svwd_pkg::SVWD_ST_RUN) && (cnt_reg == WD_LAST)
                     && !kick_edge && !kick_hiz;
  assign hold_done = (state_reg == svwd_pkg::SVWD_ST_HOLD) && (cnt_reg == RST_LAST);

  // phase sequencing and counter
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    rst_n_next = rst_n_reg;
    if (undervolt_i) begin
      state_next = svwd_pkg::SVWD_ST_UNDERVOLT;
      cnt_next = `SVWD_CNT_ZERO;
      rst_n_next = 1'b0;
    end else begin
      case (state_reg)
        svwd_pkg::SVWD_ST_UNDERVOLT: begin
          // supplies back: start the reset-hold period
          state_next = svwd_pkg::SVWD_ST_HOLD;
          cnt_next = `SVWD_CNT_ZERO;
          rst_n_next = 1'b0;
        end
        svwd_pkg::SVWD_ST_HOLD: begin
          if (hold_done) begin
            state_next = svwd_pkg::SVWD_ST_RUN;
            cnt_next = `SVWD_CNT_ZERO;
            rst_n_next = 1'b1;
          end else begin
            cnt_next = cnt_reg + `SVWD_CNT_ONE;
          end
        end
        svwd_pkg::SVWD_ST_RUN: begin
          if (kick_hiz || kick_edge) begin
            cnt_next = `SVWD_CNT_ZERO;
          end else if (wd_expire) begin
            state_next = svwd_pkg::SVWD_ST_HOLD;
            cnt_next = `SVWD_CNT_ZERO;
            rst_n_next = 1'b0;
          end else begin
            cnt_next = cnt_reg + `SVWD_CNT_ONE;
          end
        end
        default: begin
          state_next = svwd_pkg::SVWD_ST_HOLD;
          cnt_next = `SVWD_CNT_ZERO;
          rst_n_next = 1'b0;
        end
      endcase
    end
  end

  // fault latch
  always_comb begin
    fault_n_next = fault_n_reg;
    if (undervolt_i) begin
      fault_n_next = 1'b1;
    end else if (state_reg == svwd_pkg::SVWD_ST_RUN) begin
      if (wd_expire) begin
        fault_n_next = 1'b0;
      end else if (kick_edge) begin
        fault_n_next = 1'b1;
      end
    end
  end

  // phase and counter registers
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state_reg <= svwd_pkg::SVWD_ST_HOLD;
      cnt_reg <= `SVWD_CNT_ZERO;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // output registers
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rst_n_reg <= `SVWD_RST_N_INIT;
      fault_n_reg <= `SVWD_FAULT_N_INIT;
    end else begin
      rst_n_reg <= rst_n_next;
      fault_n_reg <= fault_n_next;
    end
  end

  assign sys_rst_n_o = rst_n_reg;
  assign watchdog_fault_out_n_o = fault_n_reg;

  // helper: cycles that reset has been low in a row
  logic [`SVWD_CNT_W-1:0] low_cnt_reg;
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      low_cnt_reg <= `SVWD_CNT_ZERO;
    end else if (sys_rst_n_o) begin
      low_cnt_reg <= `SVWD_CNT_ZERO;
    end else if (low_cnt_reg != {`SVWD_CNT_W{1'b1}}) begin
      low_cnt_reg <= low_cnt_reg + `SVWD_CNT_ONE;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  // a running period reaching its end without kick or float
  sequence timeout_s;
    state_reg == svwd_pkg::SVWD_ST_RUN && cnt_reg == WD_LAST && !kick_edge && !kick_hiz
      && !undervolt_i;
  endsequence

  // the hold period completing with supplies good
  sequence hold_end_s;
    state_reg == svwd_pkg::SVWD_ST_HOLD && cnt_reg == RST_LAST && !undervolt_i;
  endsequence

  // a float stretch in a running period ending with supplies good
  sequence float_end_s;
    (state_reg == svwd_pkg::SVWD_ST_RUN && kick_hiz && !undervolt_i)
      ##1 (!kick_hiz && !kick_edge && !undervolt_i);
  endsequence

  // fault latches on timeout
  timeout_fault_a : assert property (timeout_s |=> !watchdog_fault_out_n_o)
    else $error("fault not latched on watchdog timeout");

  // fault and reset fall together
  fault_rst_same_a : assert property ($fell(watchdog_fault_out_n_o) |->
      !sys_rst_n_o && $past(sys_rst_n_o))
    else $error("fault fell without reset falling in the same cycle");

  // kick ignored under reset
  kick_ignored_a : assert property ((!sys_rst_n_o && !undervolt_i
      && state_reg != svwd_pkg::SVWD_ST_RUN) |=> $stable(watchdog_fault_out_n_o))
    else $error("fault changed while reset was low");

  // hold length honoured
  hold_length_a : assert property ($rose(sys_rst_n_o) |->
      $past(low_cnt_reg) >= RST_LAST)
    else $error("reset released before the hold period");

  // undervoltage clears latch and timer
  uv_clear_a : assert property (undervolt_i |=>
      watchdog_fault_out_n_o && cnt_reg == `SVWD_CNT_ZERO)
    else $error("undervoltage did not clear fault and timer");

  // alternation after timeout
  alternate_a : assert property (timeout_s ##1 (!undervolt_i)[*2] |->
      !sys_rst_n_o && state_reg == svwd_pkg::SVWD_ST_HOLD)
    else $error("timeout did not restart the hold period");

  // fault stays low without an edge
  fault_stays_a : assert property ((!watchdog_fault_out_n_o && !kick_edge
      && !undervolt_i) |=> !watchdog_fault_out_n_o)
    else $error("fault released without a kick edge");

  // float clears timer, fault unchanged
  hiz_timer_a : assert property ((state_reg == svwd_pkg::SVWD_ST_RUN && kick_hiz
      && !undervolt_i) |=> cnt_reg == `SVWD_CNT_ZERO && $stable(watchdog_fault_out_n_o))
    else $error("float did not clear the watchdog timer");

  // hold counts through float
  hiz_hold_a : assert property ((state_reg == svwd_pkg::SVWD_ST_HOLD && kick_hiz
      && !undervolt_i && cnt_reg != RST_LAST) |=> cnt_reg == $past(cnt_reg) + `SVWD_CNT_ONE)
    else $error("float changed the hold count");

  // kick edge clears fault
  kick_clear_a : assert property ((state_reg == svwd_pkg::SVWD_ST_RUN && kick_edge
      && !undervolt_i) |=> watchdog_fault_out_n_o)
    else $error("kick edge did not clear the fault");

  // timer starts at release
  release_start_a : assert property (hold_end_s |=>
      sys_rst_n_o && cnt_reg == `SVWD_CNT_ZERO ##1 ($past(undervolt_i) || $past(kick_hiz)
      || $past(kick_edge) || cnt_reg == `SVWD_CNT_ONE))
    else $error("watchdog timer did not start at reset release");

  // supply low holds reset
  uv_rst_low_a : assert property (undervolt_i |=> !sys_rst_n_o)
    else $error("reset high during undervoltage");

  // reset falls on the timeout edge
  rst_fault_pair_a : assert property (timeout_s |=>
      $fell(sys_rst_n_o) && cnt_reg == `SVWD_CNT_ZERO)
    else $error("reset did not fall with the timeout");

  // hold keeps reset low whatever the kick does
  hold_rst_low_a : assert property ((state_reg == svwd_pkg::SVWD_ST_HOLD
      && !undervolt_i && cnt_reg != RST_LAST) |=> !sys_rst_n_o)
    else $error("reset rose before the hold period ended");

  // reset low for the whole hold after each timeout
  hold_full_a : assert property ((!sys_rst_n_o && low_cnt_reg < RST_LAST) |=>
      !sys_rst_n_o)
    else $error("reset low shorter than the hold period");

  // fault falls only on an expired period
  fault_cause_a : assert property ($fell(watchdog_fault_out_n_o) |->
      $past(state_reg) == svwd_pkg::SVWD_ST_RUN && $past(cnt_reg) == WD_LAST
      && !$past(kick_hiz) && !$past(kick_edge))
    else $error("fault fell without a watchdog timeout");

  // float in a running period never times out
  float_no_timeout_a : assert property ((state_reg == svwd_pkg::SVWD_ST_RUN
      && kick_hiz && !undervolt_i) |=> sys_rst_n_o && state_reg == svwd_pkg::SVWD_ST_RUN)
    else $error("floated kick let the watchdog time out");

  // full period after float ends
  float_end_a : assert property (float_end_s |=> cnt_reg == `SVWD_CNT_ONE)
    else $error("timer did not restart from zero after float");

  // edges only from two valid differing samples
  kick_edge_valid_a : assert property (kick_edge |->
      $past(watchdog_kick_in_i, 2) != $past(watchdog_kick_in_i, 3)
      && !$past(kick_hiz_i, 2) && !$past(kick_hiz_i, 3))
    else $error("kick edge reported without two valid samples");

  // running period means reset released
  run_rst_high_a : assert property (state_reg == svwd_pkg::SVWD_ST_RUN |-> sys_rst_n_o)
    else $error("reset low in a running period");

  // undervoltage enters the supply-low phase
  uv_state_a : assert property (undervolt_i |=>
      state_reg == svwd_pkg::SVWD_ST_UNDERVOLT)
    else $error("undervoltage did not enter the supply-low phase");

endmodule : svwd_top

// *** testbench/svwd_cpu_model.sv ***
// Purpose: processor model that kicks the watchdog and reads the fault line
// Assumes: bench commands change at the falling edge of the clock
// Notes:   a floated kick line shows a level that flips every cycle
`timescale 1ns/1ps

module svwd_cpu_model (
  // clock and bench commands
  input wire logic clk_sys_i,
  input wire logic [7:0] kick_period_i,
  input wire logic float_i,
  // supervisor outputs seen
  input wire logic sys_rst_n_i,
  input wire logic fault_n_i,
  // kick pin view and reset cause
  output logic watchdog_kick_in_o,
  output logic kick_hiz_o,
  output logic cause_wd_o
);
  logic level_reg = 1'b0;
  logic rst_prev_reg = 1'b0;
  logic [7:0] cnt_reg = 8'h00;
  logic wrap;

  // period counter wraps when a toggle is due
  assign wrap = (cnt_reg + 8'h01) >= kick_period_i;

  always @(negedge clk_sys_i) begin
    kick_hiz_o <= float_i;
    cnt_reg <= wrap ? 8'h00 : cnt_reg + 8'h01;
    if (kick_period_i != 8'h00 && wrap) begin
      level_reg <= ~level_reg;
    end
    // a released line must not hold its last value
    watchdog_kick_in_o <= float_i ? ~watchdog_kick_in_o : level_reg;
  end

  always @(posedge clk_sys_i) begin
    rst_prev_reg <= sys_rst_n_i;
    if (!rst_prev_reg && sys_rst_n_i) begin
      cause_wd_o <= ~fault_n_i;
    end
  end

  // start with the pin driven low
  initial begin
    watchdog_kick_in_o = 1'b0;
    kick_hiz_o = 1'b0;
    cause_wd_o = 1'b0;
  end
endmodule : svwd_cpu_model

// *** testbench/svwd_top_tb.sv ***
// Purpose: self-checking bench of the supervisor watchdog
// Assumes: short periods, WD_CYC 40 and RST_CYC 10
// Notes:   inputs change at the falling edge, outputs are read there too
`timescale 1ns/1ps

module svwd_top_tb;
  localparam int WD = 40;
  localparam int RC = 10;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic undervolt_i = 1'b0;
  logic [7:0] kick_period = 8'h00;
  logic kick_float = 1'b0;
  logic kick_lvl, kick_hiz, sys_rst_n, fault_n, cause_wd;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;

  svwd_top #(.WD_CYC(WD), .RST_CYC(RC)) i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .undervolt_i(undervolt_i), .watchdog_kick_in_i(kick_lvl), .kick_hiz_i(kick_hiz),
    .sys_rst_n_o(sys_rst_n), .watchdog_fault_out_n_o(fault_n));

  svwd_cpu_model i_cpu (.clk_sys_i(clk_sys_i), .kick_period_i(kick_period),
    .float_i(kick_float), .sys_rst_n_i(sys_rst_n), .fault_n_i(fault_n),
    .watchdog_kick_in_o(kick_lvl), .kick_hiz_o(kick_hiz), .cause_wd_o(cause_wd));

  // clock and hang guard
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_bit

  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : chk_rng

  // count falling edges until the chosen output reaches a level
  task automatic wait_for(input bit on_fault, input logic lvl, input int lim, output int k);
    k = 0;
    while ((on_fault ? fault_n : sys_rst_n) !== lvl && k < lim) begin
      @(negedge clk_sys_i);
      k++;
    end
  endtask : wait_for

  task automatic t_power_up();
    wait_for(0, 1'b1, 30, n);
    chk_rng("hold after reset", RC, RC + 3, n);
    chk_bit("fault after reset", 1'b1, fault_n);
    $display("test power_up done");
  endtask : t_power_up

  task automatic t_timeout();
    wait_for(1, 1'b0, 100, n);
    chk_rng("timeout length", WD, WD + 2, n);
    chk_bit("reset with fault", 1'b0, sys_rst_n);
    kick_period <= 8'h01;
    repeat (4) @(negedge clk_sys_i);
    kick_period <= 8'h00;
    wait_for(0, 1'b1, 30, n);
    chk_rng("hold length", RC - 4, RC - 1, n);
    chk_bit("fault kept in hold", 1'b0, fault_n);
    @(negedge clk_sys_i);
    chk_bit("cause read", 1'b1, cause_wd);
    wait_for(0, 1'b0, 100, n);
    chk_rng("second timeout", WD - 1, WD - 1, n);
    wait_for(0, 1'b1, 30, n);
    chk_rng("second hold", RC, RC + 2, n);
    chk_bit("fault still low", 1'b0, fault_n);
    $display("test timeout done");
  endtask : t_timeout

  task automatic t_kick();
    kick_period <= 8'h14;
    wait_for(1, 1'b1, 30, n);
    chk_rng("kick clears fault", 1, 25, n);
    wait_for(0, 1'b0, 150, n);
    chk_rng("kicked run", 150, 150, n);
    $display("test kick done");
  endtask : t_kick

  task automatic t_float();
    kick_float <= 1'b1;
    wait_for(0, 1'b0, 120, n);
    chk_rng("floated run", 120, 120, n);
    kick_float <= 1'b0;
    kick_period <= 8'h00;
    wait_for(0, 1'b0, 100, n);
    chk_rng("full period after float", WD, WD + 5, n);
    kick_float <= 1'b1;
    wait_for(0, 1'b1, 30, n);
    chk_rng("hold while floated", RC, RC + 2, n);
    chk_bit("fault kept floated", 1'b0, fault_n);
    kick_float <= 1'b0;
    $display("test float done");
  endtask : t_float

  task automatic t_undervolt();
    undervolt_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk_bit("reset on undervolt", 1'b0, sys_rst_n);
    chk_bit("fault on undervolt", 1'b1, fault_n);
    repeat (20) @(negedge clk_sys_i);
    chk_bit("reset held", 1'b0, sys_rst_n);
    undervolt_i = 1'b0;
    wait_for(0, 1'b1, 30, n);
    chk_rng("hold after undervolt", RC, RC + 3, n);
    @(negedge clk_sys_i);
    chk_bit("cause read", 1'b0, cause_wd);
    wait_for(0, 1'b0, 100, n);
    chk_rng("timer from release", WD - 1, WD + 2, n);
    $display("test undervolt done");
  endtask : t_undervolt

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    repeat (8) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    t_power_up();
    t_timeout();
    t_kick();
    t_float();
    t_undervolt();
    give_verdict();
  end
endmodule : svwd_top_tb
